// [hdl/ps2kh_link.sv]
// Functional notes
// - mode 1 one-way, modes 2/3 two-way, 2 default
// - hold clock low 60 us before sending
// - let keyboard frame finish before taking link
// - pull data low to start; keyboard clocks
// - send command byte LSb first, bit per clock
// - odd parity bit after eighth data bit
// - pull clock low after stop to inhibit
// - signal processor attention on IRQ1 line
// - EDh option byte: caps, num, scroll bits
// - F0h option byte selects mode 1..3
// - F3h byte: delay bits 6:5, rate 4:0
`timescale 1ns/1ps
`include "ps2kh_defines.svh"
module ps2kh_link
#(
  parameter int INHIBIT_CYC = `KH_INHIBIT_US * `KH_CLK_MHZ
)
(
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               kbClkIn,
  output logic                    kbClkOut,
  output logic                    kbClkOe,
  input  wire logic               kbDatIn,
  output logic                    kbDatOut,
  output logic                    kbDatOe,
  output logic                    kbIrq1
);
  import ps2kh_pkg::*;

  logic        clkLvl;
  logic        clkFall;
  logic        datLvl;

  ps2kh_sync uClkSync
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pinIn   (kbClkIn),
    .level   (clkLvl),
    .fall    (clkFall)
  );

  ps2kh_sync uDatSync
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pinIn   (kbDatIn),
    .level   (datLvl),
    .fall    ()
  );

  // bus slave state
  logic        awHeld_ff;
  logic        wHeld_ff;
  logic [7:0]  awAddr_ff;
  logic [31:0] wData_ff;
  logic        awReady_ff;
  logic        wReady_ff;
  logic        bValid_ff;
  logic [1:0]  bResp_ff;
  logic        arReady_ff;
  logic        rValid_ff;
  logic [1:0]  rResp_ff;
  logic [31:0] rData_ff;

  // block state
  ps2kh_tx_t   txState_ff;
  logic [13:0] timer_ff;
  logic [3:0]  txBit_ff;
  logic [8:0]  txShift_ff;
  ps2kh_byte_t txByte_ff;
  ps2kh_byte_t lastCmd_ff;
  logic        optPend_ff;
  logic        enable_ff;
  logic        ackOk_ff;
  logic        resend_ff;
  logic [3:0]  rxBit_ff;
  logic [8:0]  rxShift_ff;
  ps2kh_byte_t rxData_ff;
  logic        rxFull_ff;
  logic        parErr_ff;
  logic [1:0]  mode_ff;
  logic [2:0]  leds_ff;
  logic [6:0]  typem_ff;
  logic        clkOe_ff;
  logic        datOe_ff;

  // write path decode
  wire         doWrite   = awHeld_ff & wHeld_ff & ~bValid_ff;
  wire         wrCtrl    = doWrite & (awAddr_ff == `KH_ADDR_CTRL);
  wire         wrTx      = doWrite & (awAddr_ff == `KH_ADDR_TXDATA);
  wire         wrMapped  = wrCtrl | wrTx | (awAddr_ff == `KH_ADDR_STATUS)
                           | (awAddr_ff == `KH_ADDR_RXDATA)
                           | (awAddr_ff == `KH_ADDR_LEDS)
                           | (awAddr_ff == `KH_ADDR_TYPEM);
  wire         txAccept  = wrTx & (txState_ff == KH_IDLE);

  // read path decode
  wire         doRead    = s_axi_arvalid & arReady_ff;
  wire         rdRx      = doRead & (s_axi_araddr == `KH_ADDR_RXDATA);
  wire [31:0]  statusWord = {24'h00_0000, optPend_ff, mode_ff, resend_ff,
                             ackOk_ff, parErr_ff, rxFull_ff,
                             (txState_ff != KH_IDLE)};
  wire         rdHit     = (s_axi_araddr == `KH_ADDR_CTRL)
                           | (s_axi_araddr == `KH_ADDR_TXDATA)
                           | (s_axi_araddr == `KH_ADDR_STATUS)
                           | (s_axi_araddr == `KH_ADDR_RXDATA)
                           | (s_axi_araddr == `KH_ADDR_LEDS)
                           | (s_axi_araddr == `KH_ADDR_TYPEM);
  wire [31:0]  rdMux     =
    (s_axi_araddr == `KH_ADDR_CTRL)   ? {31'h0, enable_ff} :
    (s_axi_araddr == `KH_ADDR_TXDATA) ? {24'h00_0000, txByte_ff} :
    (s_axi_araddr == `KH_ADDR_STATUS) ? statusWord :
    (s_axi_araddr == `KH_ADDR_RXDATA) ? {24'h00_0000, rxData_ff} :
    (s_axi_araddr == `KH_ADDR_LEDS)   ? {29'h0, leds_ff} :
    (s_axi_araddr == `KH_ADDR_TYPEM)  ? {25'h0, typem_ff} : 32'h0000_0000;

  // link decode
  wire         txOwns    = (txState_ff == KH_SEND);
  // a start bit already on the data line counts as a frame in progress
  wire         rxIdle    = (rxBit_ff == 4'h0) & datLvl;
  wire         rxSample  = clkFall & ~txOwns & ~clkOe_ff;
  wire         rxDone    = rxSample & (rxBit_ff == `KH_BIT_STOP);
  wire         rxParOk   = ^rxShift_ff;
  wire         timerDone = (timer_ff == 14'h0000);
  wire [13:0]  inhibitLd = 14'(INHIBIT_CYC - 1);
  wire         optByte   = optPend_ff;
  wire [1:0]   optMode   = txByte_ff[1:0];
  wire         optModeOk = (txByte_ff != 8'h00) & (txByte_ff <= `KH_OPT_MODE_MAX);

  // bus channel handshakes
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      awHeld_ff  <= 1'b0;
      wHeld_ff   <= 1'b0;
      awAddr_ff  <= 8'h00;
      wData_ff   <= 32'h0000_0000;
      awReady_ff <= 1'b1;
      wReady_ff  <= 1'b1;
      bValid_ff  <= 1'b0;
      bResp_ff   <= `KH_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & awReady_ff)
      begin
        awHeld_ff  <= 1'b1;
        awAddr_ff  <= s_axi_awaddr;
        awReady_ff <= 1'b0;
      end
      if (s_axi_wvalid & wReady_ff)
      begin
        wHeld_ff  <= 1'b1;
        wData_ff  <= s_axi_wdata;
        wReady_ff <= 1'b0;
      end
      if (doWrite)
      begin
        bValid_ff <= 1'b1;
        bResp_ff  <= wrMapped ? `KH_RESP_OKAY : `KH_RESP_SLVERR;
        awHeld_ff <= 1'b0;
        wHeld_ff  <= 1'b0;
      end
      if (bValid_ff & s_axi_bready)
      begin
        bValid_ff  <= 1'b0;
        awReady_ff <= 1'b1;
        wReady_ff  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      arReady_ff <= 1'b1;
      rValid_ff  <= 1'b0;
      rResp_ff   <= `KH_RESP_OKAY;
      rData_ff   <= 32'h0000_0000;
    end
    else if (doRead)
    begin
      arReady_ff <= 1'b0;
      rValid_ff  <= 1'b1;
      rResp_ff   <= rdHit ? `KH_RESP_OKAY : `KH_RESP_SLVERR;
      rData_ff   <= rdMux;
    end
    else if (rValid_ff & s_axi_rready)
    begin
      rValid_ff  <= 1'b0;
      arReady_ff <= 1'b1;
    end
  end

  // transmit sequencer
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      txState_ff <= KH_IDLE;
      timer_ff   <= 14'h0000;
      txBit_ff   <= 4'h0;
      txShift_ff <= 9'h1FF;
      txByte_ff  <= 8'h00;
      clkOe_ff   <= 1'b0;
      datOe_ff   <= 1'b0;
      ackOk_ff   <= 1'b0;
    end
    else
    begin
      unique case (txState_ff)
        KH_IDLE:
        begin
          clkOe_ff <= ~enable_ff;
          datOe_ff <= 1'b0;
          if (txAccept)
          begin
            txByte_ff  <= wData_ff[7:0];
            txShift_ff <= {~^wData_ff[7:0], wData_ff[7:0]};
            ackOk_ff   <= 1'b0;
            txState_ff <= KH_WAITRX;
          end
        end
        KH_WAITRX:
        begin
          if (rxIdle)
          begin
            clkOe_ff   <= 1'b1;
            timer_ff   <= inhibitLd;
            txState_ff <= KH_INHIBIT;
          end
        end
        KH_INHIBIT:
        begin
          if (timerDone)
          begin
            datOe_ff   <= 1'b1;
            clkOe_ff   <= 1'b0;
            txBit_ff   <= 4'h0;
            txState_ff <= KH_SEND;
          end
          else
            timer_ff <= timer_ff - 14'h0001;
        end
        KH_SEND:
        begin
          if (clkFall)
          begin
            txBit_ff <= txBit_ff + 4'h1;
            if (txBit_ff < `KH_BIT_PARITY)
            begin
              datOe_ff   <= ~txShift_ff[0];
              txShift_ff <= {1'b1, txShift_ff[8:1]};
            end
            else if (txBit_ff == `KH_BIT_PARITY)
              datOe_ff <= 1'b0;
            else
            begin
              ackOk_ff   <= ~datLvl;
              clkOe_ff   <= 1'b1;
              timer_ff   <= inhibitLd;
              txState_ff <= KH_HOLD;
            end
          end
        end
        KH_HOLD:
        begin
          if (timerDone)
          begin
            clkOe_ff   <= 1'b0;
            txState_ff <= KH_IDLE;
          end
          else
            timer_ff <= timer_ff - 14'h0001;
        end
      endcase
    end
  end

  // receive framing
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rxBit_ff   <= 4'h0;
      rxShift_ff <= 9'h000;
      rxData_ff  <= 8'h00;
      rxFull_ff  <= 1'b0;
      parErr_ff  <= 1'b0;
      resend_ff  <= 1'b0;
    end
    else
    begin
      if (rdRx)
        rxFull_ff <= 1'b0;
      if (rxSample)
      begin
        if (rxBit_ff == 4'h0)
          rxBit_ff <= datLvl ? 4'h0 : 4'h1;
        else if (rxBit_ff != `KH_BIT_STOP)
        begin
          rxShift_ff <= {datLvl, rxShift_ff[8:1]};
          rxBit_ff   <= rxBit_ff + 4'h1;
        end
        else
          rxBit_ff <= 4'h0;
      end
      if (rxDone)
      begin
        rxData_ff <= rxShift_ff[7:0];
        rxFull_ff <= 1'b1;
        parErr_ff <= ~rxParOk | ~datLvl;
        resend_ff <= (rxShift_ff[7:0] == `KH_RPL_RESEND);
      end
    end
  end

  // command tracking and option bytes
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      enable_ff  <= 1'b1;
      lastCmd_ff <= 8'h00;
      optPend_ff <= 1'b0;
      mode_ff    <= `KH_MODE_2;
      leds_ff    <= 3'h0;
      typem_ff   <= 7'h00;
    end
    else
    begin
      if (wrCtrl)
        enable_ff <= wData_ff[`KH_CTRL_ENABLE];
      if ((txState_ff == KH_HOLD) & timerDone)
      begin
        if (optByte)
        begin
          optPend_ff <= 1'b0;
          if (lastCmd_ff == `KH_CMD_LEDS)
            leds_ff <= txByte_ff[2:0];
          else if ((lastCmd_ff == `KH_CMD_SCANSET) & optModeOk)
            mode_ff <= optMode;
          else if (lastCmd_ff == `KH_CMD_TYPEM)
            typem_ff <= txByte_ff[6:0];
        end
        else
        begin
          lastCmd_ff <= txByte_ff;
          optPend_ff <= (txByte_ff == `KH_CMD_LEDS)
                        | (txByte_ff == `KH_CMD_SCANSET)
                        | (txByte_ff == `KH_CMD_TYPEM);
          if (txByte_ff == `KH_CMD_RESET)
            mode_ff <= `KH_MODE_2;
        end
      end
    end
  end

  assign s_axi_awready = awReady_ff;
  assign s_axi_wready  = wReady_ff;
  assign s_axi_bvalid  = bValid_ff;
  assign s_axi_bresp   = bResp_ff;
  assign s_axi_arready = arReady_ff;
  assign s_axi_rvalid  = rValid_ff;
  assign s_axi_rresp   = rResp_ff;
  assign s_axi_rdata   = rData_ff;
  assign kbClkOut      = 1'b0;
  assign kbDatOut      = 1'b0;
  assign kbClkOe       = clkOe_ff;
  assign kbDatOe       = datOe_ff;
  assign kbIrq1        = rxFull_ff;
endmodule : ps2kh_link

// [include/ps2kh_defines.svh]
`ifndef PS2KH_DEFINES_SVH
`define PS2KH_DEFINES_SVH
// register byte offsets
`define KH_ADDR_CTRL    8'h00
`define KH_ADDR_TXDATA  8'h04
`define KH_ADDR_STATUS  8'h08
`define KH_ADDR_RXDATA  8'h0C
`define KH_ADDR_LEDS    8'h10
`define KH_ADDR_TYPEM   8'h14
// control fields
`define KH_CTRL_ENABLE  0
`define KH_CTRL_RESET   32'h0000_0001
// status fields
`define KH_ST_BUSY      0
`define KH_ST_RXFULL    1
`define KH_ST_PARERR    2
`define KH_ST_ACKOK     3
`define KH_ST_RESEND    4
`define KH_ST_MODE_LO   5
`define KH_ST_OPTPEND   7
// keyboard command and reply codes
`define KH_CMD_LEDS     8'hED
`define KH_CMD_SCANSET  8'hF0
`define KH_CMD_TYPEM    8'hF3
`define KH_CMD_RESET    8'hFF
`define KH_RPL_RESEND   8'hFE
// mode codes
`define KH_MODE_1       2'h1
`define KH_MODE_2       2'h2
`define KH_MODE_3       2'h3
`define KH_OPT_MODE_MAX 8'h03
// option byte fields
`define KH_LED_W        3
`define KH_TYPEM_W      7
// frame bit positions
`define KH_BIT_PARITY   4'h9
`define KH_BIT_STOP     4'hA
`define KH_BIT_LAST_TX  4'hB
// timing
`define KH_INHIBIT_US   60
`define KH_CLK_MHZ      250
// axi responses
`define KH_RESP_OKAY    2'h0
`define KH_RESP_SLVERR  2'h2
`endif

// [include/ps2kh_pkg.sv]
package ps2kh_pkg;
  typedef enum logic [2:0] {
    KH_IDLE,
    KH_WAITRX,
    KH_INHIBIT,
    KH_SEND,
    KH_HOLD
  } ps2kh_tx_t;
  typedef logic [7:0] ps2kh_byte_t;
endpackage : ps2kh_pkg

// [hdl/ps2kh_sync.sv]
`timescale 1ns/1ps
module ps2kh_sync
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic pinIn,
  output logic      level,
  output logic      fall
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;
  logic fall_ff;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      prev_ff <= 1'b1;
      fall_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= pinIn;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
      fall_ff <= prev_ff & ~sync_ff;
    end
  end

  assign level = prev_ff;
  assign fall  = fall_ff;
endmodule : ps2kh_sync

// [tb/ps2kh_kbd_model.sv]
`timescale 1ns/1ps
module ps2kh_kbd_model
#(
  parameter logic [7:0] ACK_CODE = 8'hA5, // arbitrary acknowledge code
  parameter logic [7:0] ID_LO    = 8'h5A, // arbitrary identify bytes
  parameter logic [7:0] ID_HI    = 8'h3C
)
(
  input  wire logic  clkLine,
  input  wire logic  datLine,
  output logic       clkLow,
  output logic       datLow,
  output logic       sending,
  output logic       parOk,
  output logic       holdOk,
  output logic [7:0] rxByte
);
  logic [9:0] sh;
  logic       quiet;
  // one link clock period; the clock stands still outside frames
  task automatic pulse();
    #62.5 clkLow = 1'b1;
    #62.5 clkLow = 1'b0;
  endtask : pulse
  task automatic send(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ~^b, b, 1'b0}; // start, lsb first, odd parity, stop
    wait (clkLine && datLine);
    sending = 1'b1;
    for (int i = 0; i < 11; i++)
    begin
      datLow = !f[i];
      pulse();
    end
    datLow = 1'b0;
    sending = 1'b0;
  endtask : send
  initial
  begin
    clkLow = 1'b0;
    datLow = 1'b0;
    sending = 1'b0;
    parOk = 1'b0;
    holdOk = 1'b0;
    rxByte = 8'h00;
    forever
    begin
      wait (!datLine && clkLine);
      for (int i = 0; i < 10; i++)
      begin
        pulse(); // host start answered by clock pulses
        sh[i] = datLine;
      end
      datLow = 1'b1; // low acknowledge bit after stop
      pulse();
      datLow = 1'b0;
      #20 holdOk = !clkLine;
      rxByte = sh[7:0];
      parOk = (^sh[8:0]) && sh[9];
      wait (clkLine);
      quiet = parOk && (rxByte == 8'hEF || rxByte == 8'hF1); // invalid codes unanswered
      if (!quiet)
        send(parOk ? ((rxByte == 8'hEE) ? 8'hEE : ACK_CODE) : 8'hFE);
      if (parOk && rxByte == 8'hF2)
      begin
        send(ID_LO); // two identify bytes follow the acknowledge
        send(ID_HI);
      end
    end
  end
endmodule : ps2kh_kbd_model

// [tb/ps2kh_link_checker.sv]
`timescale 1ns/1ps
module ps2kh_link_checker
#(
  parameter int INHIBIT_CYC = 15000
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic kbClkIn,
  input wire logic kbClkOut,
  input wire logic kbClkOe,
  input wire logic kbDatOut,
  input wire logic kbDatOe,
  input wire logic kbIrq1
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  int inhCnt_ff;
  int nxt_inhCnt;
  assign nxt_inhCnt = kbClkOe ? inhCnt_ff + 1 : 0;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst) inhCnt_ff <= 0;
    else inhCnt_ff <= nxt_inhCnt;
  end
  sequence sAwTake;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence sArTake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_INHIBIT_LEN: assert property ($fell(kbClkOe) && kbDatOe |-> inhCnt_ff >= INHIBIT_CYC)
    else $error("clock inhibit too short");
  AST_DAT_EDGE: assert property ($changed(kbDatOe) |-> !$past(kbClkIn))
    else $error("data changed while clock high");
  AST_CLK_OUT: assert property (kbClkOut == 1'b0)
    else $error("clock pin driven high");
  AST_DAT_OUT: assert property (kbDatOut == 1'b0)
    else $error("data pin driven high");
  AST_IRQ_RISE: assert property ($rose(kbIrq1) |-> !kbDatOe)
    else $error("byte flagged during transmit");
  AST_B_LAT: assert property (sAwTake |-> ##[1:4] s_axi_bvalid)
    else $error("write response missing");
  AST_AW_REFUSE: assert property (sAwTake |=> !s_axi_awready)
    else $error("second write taken");
  AST_R_LAT: assert property (sArTake |=> s_axi_rvalid)
    else $error("read data late");
endmodule : ps2kh_link_checker

// [tb/ps2kh_link_tb.sv]
`timescale 1ns/1ps
`include "ps2kh_defines.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module ps2kh_link_tb;
  localparam int INH = 50;
  localparam logic [7:0] ACK = 8'hA5; // arbitrary acknowledge code
  localparam logic [7:0] ID_LO = 8'h5A; // arbitrary identify bytes
  localparam logic [7:0] ID_HI = 8'h3C;
  logic clk_sys, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rxByte;
  logic [31:0] s_axi_wdata, s_axi_rdata, rData;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rResp, wResp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic kbClkIn, kbClkOut, kbClkOe, kbDatIn, kbDatOut, kbDatOe, kbIrq1;
  logic clkLow, datLow, sending, parOk, holdOk;
  int n_fail, n_tests;
  assign kbClkIn = ~(kbClkOe | clkLow);
  assign kbDatIn = ~(kbDatOe | datLow);
  ps2kh_link #(.INHIBIT_CYC(INH)) u_ps2kh_link (.clk_sys, .rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .kbClkIn, .kbClkOut, .kbClkOe, .kbDatIn, .kbDatOut, .kbDatOe, .kbIrq1);
  ps2kh_kbd_model #(.ACK_CODE(ACK), .ID_LO(ID_LO), .ID_HI(ID_HI)) u_ps2kh_kbd_model (
    .clkLine(kbClkIn), .datLine(kbDatIn), .clkLow, .datLow, .sending, .parOk, .holdOk, .rxByte);
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic axWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    wResp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axWr
  task automatic axRd(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rData = s_axi_rdata;
    rResp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axRd
  task automatic chkRd(input logic [7:0] a, input logic [31:0] e);
    axRd(a);
    `CHK(rData, e)
  endtask : chkRd
  task automatic waitIrq();
    int k;
    k = 0;
    while (kbIrq1 !== 1'b1 && k < 20000)
    begin
      @(posedge clk_sys);
      k++;
    end
  endtask : waitIrq
  task automatic xfer(input logic [7:0] b, input logic [7:0] rep);
    axWr(`KH_ADDR_TXDATA, {24'h0, b});
    waitIrq();
    `CHK(rxByte, b)
    `CHK(parOk, 1'b1)
    `CHK(holdOk, 1'b1)
    chkRd(`KH_ADDR_RXDATA, {24'h0, rep});
    repeat (3) @(posedge clk_sys);
    `CHK(kbIrq1, 1'b0)
  endtask : xfer
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial
  begin
    #300000;
    n_fail++;
    end_of_test();
  end
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    rst = 1'b1;
    n_fail = 0;
    n_tests = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    chkRd(`KH_ADDR_STATUS, 32'h0000_0040);
    chkRd(`KH_ADDR_CTRL, 32'h0000_0001);
    chkRd(8'h18, 32'h0);
    `CHK(rResp, `KH_RESP_SLVERR)
    axWr(8'h18, 32'h1);
    `CHK(wResp, `KH_RESP_SLVERR)
    axWr(`KH_ADDR_CTRL, 32'h0);
    repeat (4) @(posedge clk_sys);
    `CHK(kbClkOe, 1'b1)
    axWr(`KH_ADDR_CTRL, 32'h1);
    repeat (4) @(posedge clk_sys);
    `CHK(kbClkOe, 1'b0)
    $display("registers done");
    xfer(`KH_CMD_LEDS, ACK);
    xfer(8'h05, ACK);
    chkRd(`KH_ADDR_LEDS, 32'h5);
    xfer(`KH_CMD_TYPEM, ACK);
    xfer(8'h2B, ACK);
    chkRd(`KH_ADDR_TYPEM, 32'h2B);
    $display("options done");
    for (int m = 1; m <= 3; m++)
    begin
      xfer(`KH_CMD_SCANSET, ACK);
      xfer(8'(m), ACK);
      axRd(`KH_ADDR_STATUS);
      `CHK(rData[6:5], 2'(m))
    end
    xfer(8'hF7, ACK);
    xfer(8'hFB, ACK);
    xfer(8'h1C, ACK);
    xfer(`KH_CMD_RESET, ACK);
    axRd(`KH_ADDR_STATUS);
    `CHK(rData[6:5], `KH_MODE_2)
    xfer(8'hEE, 8'hEE);
    xfer(8'hF2, ACK);
    waitIrq();
    chkRd(`KH_ADDR_RXDATA, {24'h0, ID_LO});
    waitIrq();
    chkRd(`KH_ADDR_RXDATA, {24'h0, ID_HI});
    axWr(`KH_ADDR_TXDATA, 32'hEF);
    repeat (1200) @(posedge clk_sys);
    axRd(`KH_ADDR_STATUS);
    `CHK(rData[1:0], 2'b00)
    `CHK(rData[3], 1'b1)
    `CHK(rxByte, 8'hEF)
    $display("modes done");
    axWr(`KH_ADDR_TXDATA, 32'hF4);
    axRd(`KH_ADDR_STATUS);
    `CHK(rData[0], 1'b1)
    axWr(`KH_ADDR_TXDATA, 32'h11);
    chkRd(`KH_ADDR_TXDATA, 32'hF4);
    wait (sending);
    `CHK(rxByte, 8'hF4)
    axWr(`KH_ADDR_TXDATA, 32'hF6);
    wait (!sending);
    chkRd(`KH_ADDR_RXDATA, {24'h0, ACK});
    wait (sending);
    `CHK(rxByte, 8'hF6)
    `CHK(parOk, 1'b1)
    wait (!sending);
    repeat (10) @(posedge clk_sys);
    axRd(`KH_ADDR_STATUS);
    `CHK(rData[2], 1'b0)
    chkRd(`KH_ADDR_RXDATA, {24'h0, ACK});
    $display("collision done");
    end_of_test();
  end
endmodule : ps2kh_link_tb
bind ps2kh_link ps2kh_link_checker #(.INHIBIT_CYC(INHIBIT_CYC)) u_ps2kh_link_checker (
  .clk_sys, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .kbClkIn, .kbClkOut, .kbClkOe, .kbDatOut, .kbDatOe,
  .kbIrq1);
